// ==== pkg/fsr_cfg.svh ====
`ifndef FSR_CFG_SVH
`define FSR_CFG_SVH
// System clock rate and fastest result rate; the refresh period derives from them.
`define FSR_CLK_HZ 125000000
`define FSR_RATE_MAX_HZ 3000
`define FSR_RATE_CYC ((`FSR_CLK_HZ + `FSR_RATE_MAX_HZ - 1) / `FSR_RATE_MAX_HZ)
// Serial word layout.
`define FSR_BIT_ADDR 5'h07
`define FSR_BIT_LAST 5'h0f
`define FSR_WR_POS 13
`define FSR_RD_POS 12
`define FSR_RD_EARLY 4
`define FSR_REG_MSB 9
`define FSR_REG_LSB 8
// Configuration register numbers and reset values.
`define FSR_REG_PRI 2'h0
`define FSR_REG_OPT 2'h1
`define FSR_REG_TMP 2'h2
`define FSR_CFG0_RST 8'h00
`define FSR_CFG1_RST 8'h00
`define FSR_CFG2_RST 8'h08
// Field positions inside the registers.
`define FSR_OS_MSB 1
`define FSR_OS_LSB 0
`define FSR_RE_MSB 5
`define FSR_RE_LSB 4
`define FSR_MA_MSB 7
`define FSR_MA_LSB 6
`define FSR_SP_POS 0
// Result value at zero field and buffer depth.
`define FSR_ZERO_FIELD 16'h8000
`define FSR_FIFO_DEPTH 32
`endif

// ==== pkg/fsr_pkg.sv ====
`default_nettype none
package fsr_pkg;
  // Channel codes of the output multiplexer.
  typedef enum logic [1:0] {FSR_CH_X, FSR_CH_Y, FSR_CH_Z, FSR_CH_TEMP} fsr_chan_e;
  // One conversion result.
  typedef logic [15:0] fsr_word_t;
endpackage
`default_nettype wire

// ==== core/fsr_fifo.sv ====
`timescale 1ns/10ps
`default_nettype none
module fsr_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 32
) (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Filling side.
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Draining side.
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);

  // Storage and pointers; the count is one bit wider to tell full from empty.
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  // Honest flags from the count.
  assign in_ready_out = (count != (AW+1)'(DEPTH));
  assign out_valid_out = (count != '0);
  assign out_data_out = mem[rd_ptr];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  // Next pointer and count values.
  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Pointer registers.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // Storage write; the array needs no reset.
  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end
endmodule
`default_nettype wire

// ==== core/fsr_readout.sv ====
// Overview of operation
// - Mode 0: clock idles low, rising edge samples.
// - Sixteen-bit words, most significant bit first.
// - One result out, one config in, per word.
// - Data out tristated while chip select high.
// - Result rate selectable 0.375 to 3 kHz.
// - Delivered bit count follows resolution, 14-16.
// - Resolution applies equally to all channels.
// - Hold input resets and halts conversion.
// - Hold raises ready; select toggle clears it.
// - Ready on pin, or on data out by option.
// - Ready on load only when all selected axes fresh.
// - Select falling clears ready until next load or hold.
// - Output buffer refreshed at result rate.
// - Output stage plus channel multiplexer to serial.
// - Single-axis: unselected axes read zero field.
// - Bit 13 write, 12 read, 9:8 register.
// - Output select: X, Y, Z, temperature.
// - Registers hold value; read-back in same word.
`timescale 1ns/10ps
`default_nettype none
`include "fsr_cfg.svh"
module fsr_readout
  import fsr_pkg::*;
#(
  parameter int RATE_CYC = `FSR_RATE_CYC,
  parameter int FIFO_DEPTH = `FSR_FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Serial link pins.
  input wire logic spi_clk_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_mosi_in,
  output logic spi_miso_out,
  output logic spi_miso_oe_out,
  // Ready pin and conversion hold pin.
  output logic result_ready_flag_out,
  input wire logic conv_hold_in,
  // Converter result stream.
  input wire logic adc_valid_in,
  output logic adc_ready_out,
  input wire logic [1:0] adc_chan_in,
  input wire logic [15:0] adc_data_in,
  // Settings seen by the converters.
  output logic conv_run_out,
  output logic [1:0] conversion_rate_select_out,
  output logic [1:0] axis_select_out
);
  localparam int TW = 20;

  // ***************************************
  // Helper functions
  // ***************************************

  // Clears the bits below the delivered width for the resolution code.
  function automatic fsr_word_t fmt_bits(input fsr_word_t d, input logic [1:0] re);
    fsr_word_t m;
    m = (re == 2'h0) ? 16'hfffc : ((re == 2'h1) ? 16'hfffe : 16'hffff);
    return d & m;
  endfunction

  // Maps a measurement axis code to the channels needing fresh data.
  function automatic logic [3:0] need_mask(input logic [1:0] ma);
    logic [3:0] m;
    m = 4'h0;
    m[FSR_CH_TEMP] = 1'b1;
    if (ma == 2'h0) begin
      m = 4'hf;
    end else begin
      m[ma - 2'h1] = 1'b1;
    end
    return m;
  endfunction

  // ***************************************
  // Pin synchronisers
  // ***************************************

  // Bit 0 clock, 1 select, 2 data in, 3 hold.
  logic [3:0] sync1, sync2;
  logic [3:0] prev;
  logic sclk_rise, sclk_fall, cs_fall, cs_low, mosi, hold, hold_rise;

  // Two flops per pin, then a third stage for edge finding.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      sync1 <= 4'h2;
      sync2 <= 4'h2;
      prev <= 4'h2;
    end else begin
      sync1 <= {conv_hold_in, spi_mosi_in, spi_cs_n_in, spi_clk_in};
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  // Edge and level decode on the synchronised copies only.
  assign sclk_rise = sync2[0] & ~prev[0];
  assign sclk_fall = ~sync2[0] & prev[0];
  assign cs_fall = ~sync2[1] & prev[1];
  assign cs_low = ~sync2[1];
  assign mosi = sync2[2];
  assign hold = sync2[3];
  assign hold_rise = sync2[3] & ~prev[3];

  // ***************************************
  // Serial shifter and configuration
  // ***************************************

  logic [15:0] rx, next_rx; // Incoming word, filled from the right.
  logic [4:0] bit_cnt, next_bit_cnt; // Rising edges seen in this word.
  logic [3:0] out_idx, next_out_idx; // Falling edges seen in this word.
  logic [15:0] tx_word, next_tx_word; // Word being shifted out.
  logic [7:0] cfg [3]; // Volatile configuration registers.
  logic [7:0] next_cfg [3];
  logic miso, next_miso; // Registered data out bit.
  logic wr_ev; // A full word asks for a register write.
  logic [1:0] wr_addr; // Register number of that write.
  logic [7:0] wr_val; // Value of that write.
  fsr_word_t obuf [4]; // Serial output buffer, one word per channel.
  logic flag; // Result ready flag.

  // Returns a register for read-back, zero for the unused number.
  function automatic logic [7:0] cfg_read(input logic [1:0] a, input logic [7:0] r0,
                                          input logic [7:0] r1, input logic [7:0] r2);
    return (a == `FSR_REG_PRI) ? r0 : ((a == `FSR_REG_OPT) ? r1 :
           ((a == `FSR_REG_TMP) ? r2 : 8'h00));
  endfunction

  // Next values of the shifter and registers.
  always_comb begin
    next_rx = rx;
    next_bit_cnt = bit_cnt;
    next_out_idx = out_idx;
    next_tx_word = tx_word;
    next_cfg = cfg;
    wr_ev = 1'b0;
    wr_addr = rx[`FSR_REG_MSB-1:`FSR_REG_LSB-1];
    wr_val = {rx[6:0], mosi};
    if (cs_fall) begin
      // A new word starts: pick the requested channel from the buffer.
      next_bit_cnt = 5'h00;
      next_out_idx = 4'h0;
      next_rx = 16'h0000;
      next_tx_word = obuf[cfg[0][`FSR_OS_MSB:`FSR_OS_LSB]];
      if (cfg[`FSR_REG_OPT][`FSR_SP_POS]) begin
        // Option: the flag takes the place of the first bit.
        next_tx_word[15] = flag;
      end
    end else if (cs_low) begin
      if (sclk_rise) begin
        // Sample data in, most significant bit first.
        next_rx = {rx[14:0], mosi};
        next_bit_cnt = bit_cnt + 5'h01;
        if (bit_cnt == `FSR_BIT_ADDR && next_rx[`FSR_RD_EARLY]) begin
          // Read-back replaces the low byte of this very word.
          next_tx_word[7:0] = cfg_read(next_rx[1:0], cfg[0], cfg[1], cfg[2]);
        end
        if (bit_cnt == `FSR_BIT_LAST && next_rx[`FSR_WR_POS]) begin
          // A full word with the write bit stores its value, except to register number 3.
          wr_ev = (wr_addr != 2'h3);
          if (wr_ev) begin
            next_cfg[wr_addr] = wr_val;
          end
        end
      end
      if (sclk_fall && bit_cnt != 5'h00 && out_idx != 4'hf) begin
        // Advance the output bit after the master has sampled it.
        next_out_idx = out_idx + 4'h1;
      end
    end
    next_miso = tx_word[4'hf - out_idx];
  end

  // Shifter and register flops.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rx <= 16'h0000;
      bit_cnt <= 5'h00;
      out_idx <= 4'h0;
      tx_word <= 16'h0000;
      miso <= 1'b0;
      cfg[0] <= `FSR_CFG0_RST;
      cfg[1] <= `FSR_CFG1_RST;
      cfg[2] <= `FSR_CFG2_RST;
    end else begin
      rx <= next_rx;
      bit_cnt <= next_bit_cnt;
      out_idx <= next_out_idx;
      tx_word <= next_tx_word;
      miso <= next_miso;
      cfg <= next_cfg;
    end
  end

  // Data out is driven only while selected.
  assign spi_miso_oe_out = cs_low;
  assign spi_miso_out = miso;

  // ***************************************
  // Result stream and output stage
  // ***************************************

  logic [1:0] re, ma;
  logic fifo_valid, drain;
  logic [17:0] fifo_data;
  fsr_word_t stage [4], next_stage [4]; // Latest value per converter.
  fsr_word_t next_obuf [4];
  logic [3:0] fresh, next_fresh; // Channels updated since last load.
  logic [TW-1:0] tick_cnt, next_tick_cnt; // Refresh period counter.
  logic [TW-1:0] period;
  logic tick, load, next_flag;

  assign re = cfg[0][`FSR_RE_MSB:`FSR_RE_LSB];
  assign ma = cfg[0][`FSR_MA_MSB:`FSR_MA_LSB];
  assign drain = ~hold; // Held converters stall the buffer.

  // Buffer between converters and the output stage.
  fsr_fifo #(
    .WIDTH(18),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .in_valid_in(adc_valid_in),
    .in_ready_out(adc_ready_out),
    .in_data_in({adc_chan_in, adc_data_in}),
    .out_valid_out(fifo_valid),
    .out_ready_in(drain),
    .out_data_out(fifo_data)
  );

  // Each resolution step halves the rate from the fastest one.
  assign period = TW'(RATE_CYC) << re;
  assign tick = (tick_cnt >= period - TW'(1)); // A shortened period still ends at once.
  assign load = tick && ((fresh & need_mask(ma)) == need_mask(ma));

  // Next values of the output stage, buffer and flag.
  always_comb begin
    next_stage = stage;
    next_obuf = obuf;
    next_fresh = fresh;
    next_flag = flag;
    next_tick_cnt = tick ? TW'(0) : tick_cnt + TW'(1);
    if (load) begin
      // Refresh the serial buffer at the result rate.
      for (int i = 0; i < 4; i++) begin
        next_obuf[i] = fmt_bits(stage[i], re);
        if (i != int'(FSR_CH_TEMP) && ma != 2'h0 && i != int'(ma) - 1) begin
          next_obuf[i] = `FSR_ZERO_FIELD;
        end
      end
      next_fresh = 4'h0;
    end
    if (cs_fall) begin
      next_flag = 1'b0;
    end
    if (load || hold_rise) begin
      // A load or a hold raises the flag, winning over a clear.
      next_flag = 1'b1;
    end
    if (hold) begin
      // Conversion held in reset.
      next_tick_cnt = TW'(0);
      next_fresh = 4'h0;
    end else if (fifo_valid) begin
      next_stage[fifo_data[17:16]] = fifo_data[15:0];
      next_fresh[fifo_data[17:16]] = 1'b1;
    end
  end

  // Output stage and flag flops.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < 4; i++) begin
        stage[i] <= `FSR_ZERO_FIELD;
        obuf[i] <= `FSR_ZERO_FIELD;
      end
      fresh <= 4'h0;
      tick_cnt <= '0;
      flag <= 1'b0;
    end else begin
      stage <= next_stage;
      obuf <= next_obuf;
      fresh <= next_fresh;
      tick_cnt <= next_tick_cnt;
      flag <= next_flag;
    end
  end

  // Flag pin and settings to the converters.
  assign result_ready_flag_out = flag & ~cfg[`FSR_REG_OPT][`FSR_SP_POS];
  assign conv_run_out = ~hold;
  assign conversion_rate_select_out = re;
  assign axis_select_out = ma;

  // ***************************************
  // Checks
  // ***************************************

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  a_miso_idle_hiz: assert property (sync2[1] |-> !spi_miso_oe_out)
    else $error("Data out enabled while deselected.");
  a_flag_sel_clear: assert property (cs_fall && !load && !hold_rise |=> !flag)
    else $error("Ready flag not cleared by select.");
  a_hold_flag_set: assert property (hold_rise |=> flag)
    else $error("Hold did not raise ready flag.");
  a_hold_halts: assert property (hold |=> fresh == 4'h0 && tick_cnt == '0)
    else $error("Conversion not halted under hold.");
  a_flag_cause: assert property ($rose(flag) |-> $past(load) || $past(hold_rise))
    else $error("Ready flag rose without fresh data.");
  a_cfg_write: assert property (wr_ev |=> cfg[$past(wr_addr)] == $past(wr_val))
    else $error("Register write lost.");
  a_word_start: assert property (cs_fall |=> bit_cnt == 5'h00 && out_idx == 4'h0)
    else $error("Word counters not restarted.");
  a_single_zero: assert property (load && ma == 2'h1 |=>
    obuf[1] == `FSR_ZERO_FIELD && obuf[2] == `FSR_ZERO_FIELD)
    else $error("Unselected axis not zero field.");
endmodule
`default_nettype wire

// ==== dv/fsr_spi_master.sv ====
`timescale 1ns/10ps
`default_nettype none
// ********************************
// Serial master model, mode 0, 125 ns clock.
// ********************************
module fsr_spi_master (
  // Serial link pins.
  input wire logic miso_in,
  output logic sclk_out,
  output logic cs_n_out,
  output logic mosi_out
);
  // Last received word and the event that marks its end.
  logic [15:0] rx_word;
  event done;
  // Idle: select high, clock low and still between words.
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
    rx_word = 16'h0000;
  end
  // Sends one word while collecting the reply, top bit first.
  task automatic xfer(input logic [15:0] tx);
    cs_n_out = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi_out = tx[i];
      #62.5;
      sclk_out = 1'b1;
      rx_word[i] = miso_in;
      #62.5;
      sclk_out = 1'b0;
    end
    #62.5;
    cs_n_out = 1'b1;
    mosi_out = ~mosi_out;
    -> done;
    #150;
  endtask
endmodule
`default_nettype wire

// ==== dv/fsr_readout_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
// ********************************
// Self-checking bench of the readout block.
// ********************************
module fsr_readout_tb
  import fsr_pkg::*;
;
  localparam int RC = 50;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic conv_hold_in = 1'b0;
  logic adc_valid_in = 1'b0;
  logic [1:0] adc_chan_in = 2'h0;
  fsr_word_t adc_data_in = 16'h0000;
  wire logic sclk, cs_n, mosi, miso, oe, flag, adc_ready, run;
  wire logic [1:0] rate, axis;
  wire logic miso_w;
  logic miso_hold = 1'b0;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  fsr_word_t seed = 16'h0011;
  fsr_word_t d [4];
  fsr_word_t exp_q [$];
  fsr_word_t msk_q [$];
  always #4 clk_sys_in = ~clk_sys_in;
  fsr_readout #(.RATE_CYC(RC), .FIFO_DEPTH(32)) dut (.clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in), .spi_clk_in(sclk), .spi_cs_n_in(cs_n), .spi_mosi_in(mosi),
    .spi_miso_out(miso), .spi_miso_oe_out(oe), .result_ready_flag_out(flag),
    .conv_hold_in(conv_hold_in), .adc_valid_in(adc_valid_in), .adc_ready_out(adc_ready),
    .adc_chan_in(adc_chan_in), .adc_data_in(adc_data_in), .conv_run_out(run),
    .conversion_rate_select_out(rate), .axis_select_out(axis));
  fsr_spi_master master (.miso_in(miso_w), .sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi));
  // A released data line shows the inverse of its last driven value.
  assign miso_w = oe ? miso : ~miso_hold;
  always @(miso) if (oe) miso_hold = miso;
  // Cuts a hang short.
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      end_sim();
    end
  end
  function automatic fsr_word_t lfsr(input fsr_word_t s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk_word(input fsr_word_t got, input fsr_word_t exp, input fsr_word_t msk);
    checks_done++;
    if ((got & msk) !== (exp & msk)) begin
      n_errors++;
      $display("wrong value at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: bit %b, expected %b", $time, got, exp);
    end
  endtask
  // Notes the expected reply, then runs the word.
  task automatic xfer(input fsr_word_t tx, input fsr_word_t exp, input fsr_word_t msk);
    @(negedge clk_sys_in);
    exp_q.push_back(exp);
    msk_q.push_back(msk);
    master.xfer(tx);
  endtask
  // Watches replies and takes the oldest note for each.
  always @(master.done) begin
    fsr_word_t e;
    fsr_word_t k;
    if (exp_q.size() == 0) begin
      n_errors++;
      $display("wrong value at %0t: reply without note", $time);
    end else begin
      e = exp_q.pop_front();
      k = msk_q.pop_front();
      chk_word(master.rx_word, e, k);
    end
  end
  task automatic adc_put(input logic [1:0] ch, input fsr_word_t v);
    @(negedge clk_sys_in);
    adc_valid_in = 1'b1;
    adc_chan_in = ch;
    adc_data_in = v;
    // Ready is read between edges, where it has settled for the next rising edge.
    while (adc_ready !== 1'b1) @(negedge clk_sys_in);
    @(negedge clk_sys_in);
    adc_valid_in = 1'b0;
  endtask
  task automatic feed();
    for (int c = 0; c < 4; c++) begin
      seed = lfsr(seed);
      d[c] = seed;
      adc_put(2'(c), seed);
    end
  endtask
  task automatic wait_flag();
    for (int i = 0; i < 1000 && flag !== 1'b1; i++) @(negedge clk_sys_in);
    chk_bit(flag, 1'b1);
  endtask
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ********************************
  // Main sequence.
  // ********************************
  initial begin
    int n;
    repeat (8) @(negedge clk_sys_in);
    sys_rst_in = 1'b0;
    repeat (6) @(negedge clk_sys_in);
    chk_bit(oe, 1'b0);
    chk_bit(flag, 1'b0);
    chk_bit(run, 1'b1);
    xfer(16'h2000, 16'h8000, 16'hffff);
    feed();
    wait_flag();
    for (int c = 0; c < 4; c++) begin
      xfer(16'h2000 | 16'((c + 1) % 4), d[c] & 16'hfffc, 16'hffff);
      chk_bit(flag, 1'b0);
      chk_bit(oe, 1'b0);
    end
    $display("test three_axis done");
    xfer(16'h1200, 16'h0008, 16'h00ff);
    xfer(16'h2218, 16'h0000, 16'h0000);
    xfer(16'h23ff, 16'h0000, 16'h0000);
    xfer(16'h1300, 16'h0000, 16'h00ff);
    xfer(16'h1200, 16'h0018, 16'h00ff);
    xfer(16'h1000, 16'h0000, 16'h00ff);
    $display("test read_back done");
    xfer(16'h2101, 16'h0000, 16'h0000);
    feed();
    repeat (300) @(negedge clk_sys_in);
    chk_bit(flag, 1'b0);
    // With the option on, the top bit of the X word carries the raised flag.
    xfer(16'h2100, (d[0] & 16'hfffc) | 16'h8000, 16'hffff);
    $display("test ready_on_data done");
    xfer(16'h2061, 16'h0000, 16'h0000);
    feed();
    wait_flag();
    chk_word({12'h000, rate, axis}, 16'h0009, 16'hffff);
    xfer(16'h2060, 16'h8000, 16'hffff);
    xfer(16'h2063, d[0], 16'hffff);
    xfer(16'h2063, d[3], 16'hffff);
    $display("test single_axis done");
    // Fifteen bits, Z axis only, Z channel asked for in the next word.
    xfer(16'h20d2, 16'h0000, 16'h0000);
    feed();
    wait_flag();
    chk_word({12'h000, rate, axis}, 16'h0007, 16'hffff);
    xfer(16'h20d0, d[2] & 16'hfffe, 16'hffff);
    xfer(16'h20d1, 16'h8000, 16'hffff);
    $display("test fifteen_bit done");
    @(negedge clk_sys_in);
    conv_hold_in = 1'b1;
    repeat (10) @(negedge clk_sys_in);
    chk_bit(run, 1'b0);
    chk_bit(flag, 1'b1);
    n = 0;
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      adc_valid_in = 1'b1;
      adc_chan_in = 2'h3;
      adc_data_in = seed;
      // Ready has settled here and holds through the next rising edge.
      if (adc_ready === 1'b1) n++;
      @(negedge clk_sys_in);
    end
    adc_valid_in = 1'b0;
    chk_word(16'(n), 16'h0020, 16'hffff);
    chk_bit(adc_ready, 1'b0);
    conv_hold_in = 1'b0;
    repeat (80) @(negedge clk_sys_in);
    chk_bit(run, 1'b1);
    chk_bit(adc_ready, 1'b1);
    xfer(16'h0000, 16'h0000, 16'h0000);
    chk_bit(flag, 1'b0);
    $display("test hold done");
    end_sim();
  end
endmodule
`default_nettype wire
